// *** bench/sfr_motor_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sfr_motor_model (
  input  wire               clk,
  input  wire [15:0]        freqIn,
  input  wire               reverseIn,
  output reg  signed [16:0] shaftSpeed_reg
);
  // Stage follows one cycle late; slip is not modelled
  always @(posedge clk)
    shaftSpeed_reg <= reverseIn ? -$signed({1'b0, freqIn}) :
                                  $signed({1'b0, freqIn});
endmodule // sfr_motor_model
`default_nettype wire

// *** bench/sfr_start_ramp_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module sfr_start_ramp_assertions #(
  parameter TICK_CYCLES = 40
) (
  input wire        clk,
  input wire        rst,
  input wire        startPin,
  input wire [15:0] frequencyCommand,
  input wire [15:0] startingFrequencySetting,
  input wire [15:0] startHoldDuration,
  input wire [15:0] minimumFrequencySetting,
  input wire [15:0] outFreq_reg,
  input wire        running_reg,
  input wire        holding_reg
);
  // Out-of-range start setting falls back to 0.5 Hz
  wire [15:0] startEff = (startingFrequencySetting > 16'h1770) ?
                         16'h0032 : startingFrequencySetting;
  wire [15:0] holdFreq = (startEff == 16'h0000) ? 16'h0001 : startEff;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_idle; !running_reg |-> outFreq_reg == 16'h0000; endproperty
  a_idle: assert property (p_idle)
    else $error("output nonzero while stopped");
  property p_hrun; holding_reg |-> running_reg; endproperty
  a_hrun: assert property (p_hrun)
    else $error("holding while stopped");
  property p_first;
    $rose(running_reg) |-> outFreq_reg == (holding_reg ? holdFreq : startEff);
  endproperty
  a_first: assert property (p_first)
    else $error("wrong first frequency");
  property p_hval; holding_reg |-> outFreq_reg == holdFreq; endproperty
  a_hval: assert property (p_hval)
    else $error("wrong hold frequency");
  property p_tick;
    $changed(outFreq_reg) && running_reg && $past(running_reg)
      |=> ($stable(outFreq_reg) || !$past(running_reg))[*8];
  endproperty
  a_tick: assert property (p_tick)
    else $error("output stepped twice within a tick");
  property p_drop; holding_reg && !startPin |-> ##[1:6] !holding_reg;
  endproperty
  a_drop: assert property (p_drop)
    else $error("hold kept after start dropped");
  property p_hoff;
    $rose(running_reg) && startHoldDuration > 16'h03e8 |-> !holding_reg;
  endproperty
  a_hoff: assert property (p_hoff)
    else $error("hold applied while disabled");
  property p_take;
    $rose(running_reg) |-> $past(frequencyCommand) >= startEff ||
                           startEff <= minimumFrequencySetting;
  endproperty
  a_take: assert property (p_take)
    else $error("started below starting frequency");

  c_hold: cover property ($rose(holding_reg));
  c_hend: cover property ($fell(holding_reg) && running_reg);
  c_stop: cover property ($fell(running_reg));
endmodule // sfr_start_ramp_assertions

bind sfr_start_ramp sfr_start_ramp_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_u (
  .clk                      (clk),
  .rst                      (rst),
  .startPin                 (startPin),
  .frequencyCommand         (frequencyCommand),
  .startingFrequencySetting (startingFrequencySetting),
  .startHoldDuration        (startHoldDuration),
  .minimumFrequencySetting  (minimumFrequencySetting),
  .outFreq_reg              (outFreq_reg),
  .running_reg              (running_reg),
  .holding_reg              (holding_reg)
);
`default_nettype wire

// *** bench/test_start_frequency_ramp_profile.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_start_frequency_ramp_profile;
  localparam int T = 40;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        startPin = 1'b0;
  logic        reversePin = 1'b0;
  logic [15:0] cmd = 16'h0000;
  logic [15:0] sf = 16'h0000;
  logic [15:0] hold = 16'h270f;
  logic [15:0] minF = 16'h0000;
  logic [15:0] baseF = 16'h03e8;
  logic [15:0] refF = 16'h03e8;
  logic [1:0]  pat = 2'h0;
  logic [19:0] accT = 20'h0000a;
  logic [19:0] decT = 20'h0000a;
  logic [15:0] firstStep;
  logic [15:0] maxStep;
  logic [31:0] seed = 32'h77be;
  wire  [15:0] outFreq;
  wire         rev;
  wire         run;
  wire         hld;
  wire signed [16:0] speed;
  int          fail_count = 0;
  int          num_checks = 0;
  int          i;
  time         t0;

  sfr_start_ramp #(.TICK_CYCLES(T)) dut_u (
    .clk(clk), .rst(rst), .startPin(startPin), .reversePin(reversePin),
    .frequencyCommand(cmd), .startingFrequencySetting(sf),
    .startHoldDuration(hold), .rampPatternSelect(pat),
    .minimumFrequencySetting(minF), .baseFrequencySetting(baseF),
    .rampReferenceFrequency(refF), .accelTimeSetting(accT),
    .decelTimeSetting(decT), .outFreq_reg(outFreq), .reverse_reg(rev),
    .running_reg(run), .holding_reg(hld));

  sfr_motor_model motor_u (.clk(clk), .freqIn(outFreq),
    .reverseIn(rev), .shaftSpeed_reg(speed));

  initial
  begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [15:0] expStep(input logic [15:0] r,
                                          input logic [19:0] t);
    return 16'(r / t);
  endfunction

  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Select 0 waits on run, 1 on hld
  task automatic waitUntil(input int sel, input logic v);
    int n;
    n = 0;
    while ((sel == 0 ? run : hld) !== v)
    begin
      @(negedge clk);
      n++;
      if (n > 20000)
      begin
        fail_count++;
        give_verdict();
      end
    end
  endtask

  // Tracks first and largest step until the target is met
  task automatic ramp(input logic [15:0] tgt);
    logic [15:0] last;
    logic [15:0] d;
    int          n;
    last = outFreq;
    firstStep = 16'h0000;
    maxStep = 16'h0000;
    n = 0;
    while (outFreq !== tgt && n < 20000)
    begin
      @(negedge clk);
      n++;
      d = outFreq > last ? outFreq - last : last - outFreq;
      if (d != 0 && firstStep == 0)
        firstStep = d;
      if (d > maxStep)
        maxStep = d;
      last = outFreq;
    end
    check(outFreq, tgt);
    // A ramp that never lands ends the run here
    if (outFreq !== tgt)
      give_verdict();
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    sf = 16'h01f4;
    cmd = 16'h0190;
    startPin = 1'b1;
    repeat (5 * T) @(negedge clk);
    check(run, 1'b0);
    cmd = 16'h03e8;
    waitUntil(0, 1'b1);
    check(outFreq, sf);
    check(hld, 1'b0);
    ramp(cmd);
    check(firstStep, expStep(refF, accT));
    for (i = 0; i < 4; i++)
    begin
      seed = nextRand(seed);
      refF = 16'(100 * (seed[2:0] + 1));
      cmd = 16'(seed[15:8]) + (i[0] ? 16'h0258 : 16'h0a28);
      ramp(cmd);
      check(maxStep, expStep(refF, i[0] ? decT : accT));
    end
    refF = 16'h03e8;
    cmd = 16'h0000;
    ramp(16'h0000);
    startPin = 1'b0;
    waitUntil(0, 1'b0);
    // Let the pin filter see start low before raising it again
    repeat (6) @(negedge clk);
    sf = 16'h0000;
    hold = 16'h0005;
    cmd = 16'h03e8;
    startPin = 1'b1;
    waitUntil(1, 1'b1);
    check(outFreq, 16'h0001);
    t0 = $time;
    waitUntil(1, 1'b0);
    check(($time - t0) / 50 >= 4 * T && ($time - t0) / 50 <= 5 * T + 2,
          1'b1);
    ramp(cmd);
    startPin = 1'b0;
    waitUntil(0, 1'b0);
    hold = 16'h0064;
    startPin = 1'b1;
    waitUntil(1, 1'b1);
    repeat (20) @(negedge clk);
    startPin = 1'b0;
    repeat (6) @(negedge clk);
    check(hld, 1'b0);
    waitUntil(0, 1'b0);
    sf = 16'h00c8;
    hold = 16'h0005;
    cmd = 16'h0320;
    startPin = 1'b1;
    waitUntil(1, 1'b1);
    waitUntil(1, 1'b0);
    ramp(cmd);
    reversePin = 1'b1;
    waitUntil(0, 1'b0);
    waitUntil(0, 1'b1);
    check({rev, hld, outFreq}, {2'b10, sf});
    // The stage follows one cycle late
    @(negedge clk);
    check(speed, -$signed({1'b0, sf}));
    startPin = 1'b0;
    waitUntil(0, 1'b0);
    reversePin = 1'b0;
    sf = 16'h0032;
    hold = 16'h03e9;
    minF = 16'h012c;
    cmd = 16'h0000;
    startPin = 1'b1;
    waitUntil(0, 1'b1);
    check(hld, 1'b0);
    ramp(minF);
    check(outFreq, minF);
    startPin = 1'b0;
    waitUntil(0, 1'b0);
    minF = 16'h0000;
    baseF = 16'h0320;
    for (i = 1; i < 4; i++)
    begin
      pat = 2'(i);
      cmd = 16'h07d0;
      startPin = 1'b1;
      waitUntil(0, 1'b1);
      ramp(cmd);
      if (i == 3)
        check(maxStep, expStep(refF, accT));
      else if (i == 2)
        check(firstStep < maxStep, 1'b1);
      else
        check(firstStep < maxStep, 1'b1);
      startPin = 1'b0;
      cmd = 16'h0000;
      waitUntil(0, 1'b0);
    end
    // Zero ramp time jumps to the target at the next tick
    pat = 2'h0;
    accT = 20'h00000;
    cmd = 16'h05dc;
    startPin = 1'b1;
    waitUntil(0, 1'b1);
    ramp(cmd);
    check(maxStep, cmd - sf);
    give_verdict();
  end
endmodule // test_start_frequency_ramp_profile
`default_nettype wire

// *** rtl/sfr_defines.vh ***
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH

// Frequencies are in 0.01 Hz units, times in 0.01 s units
`define SFR_FW              16
`define SFR_TW              20
`define SFR_AW              24
`define SFR_PW              2

// Starting frequency: range 0 to 60 Hz, default 0.5 Hz
`define SFR_START_MAX       16'h1770
`define SFR_START_DEF       16'h0032
// Frequency held when the starting frequency is 0 Hz (0.01 Hz)
`define SFR_HOLD_FREQ_ZERO  16'h0001
// Start-hold time: range 0 to 10 s, 9999 turns the hold off
`define SFR_HOLD_MAX        16'h03e8
`define SFR_HOLD_OFF        16'h270f

// Ramp pattern codes
`define SFR_PAT_LIN         2'h0
`define SFR_PAT_SA          2'h1
`define SFR_PAT_SB          2'h2

// Control tick of 10 ms; one tick equals one 0.01 s unit of ramp time
`define SFR_TICK_NS         10000000
`define SFR_CLK_NS          50

// Profile states
`define SFR_ST_IDLE         2'h0
`define SFR_ST_HOLD         2'h1
`define SFR_ST_RUN          2'h2

`endif

// *** rtl/sfr_pin_sync.v ***
`timescale 1ns/10ps
`default_nettype none

module sfr_pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut_reg
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gBit
      // A change counts only once the second and third stages agree
      always @(posedge clk)
      begin
        if (rst)
        begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
          stage3_reg[i] <= 1'b0;
          pinOut_reg[i] <= 1'b0;
        end
        else
        begin
          stage1_reg[i] <= pinIn[i];
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          if (stage2_reg[i] == stage3_reg[i])
            pinOut_reg[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

endmodule // sfr_pin_sync

`default_nettype wire

// *** rtl/sfr_start_ramp.v ***
`timescale 1ns/10ps
`default_nettype none
`include "sfr_defines.vh"

// How it works
// R01: A starting frequency of 0 to 60 Hz (default 0.5 Hz) is the first output frequency at start.
// R02: A hold time of 0 to 10 s is accepted, and 9999 (the default) turns the start hold off.
// R03: The output stays stopped until the command reaches the starting frequency.
// R04: With hold on, the output rests at the starting frequency for the hold time, then ramps.
// R05: A starting frequency of 0 Hz is held as 0.01 Hz during the hold.
// R06: Dropping start during the hold ends it and deceleration begins at once.
// R07: A direction reversal restarts at the starting frequency without any hold.
// R08: With starting frequency at or below the minimum, start alone runs at the minimum frequency.
// R09: Pattern code 0 is linear (default), 1 is S-curve A, 2 is S-curve B.
// R10: Linear ramps change frequency at a constant rate both up and down.
// R11: S-curve A has its inflection point at the base frequency.
// R12: S-curve A ramp time is the time to reach the base frequency; the code reaches it from 0 Hz in 4/3 of the ramp time.
// R13: S-curve B ramps in an S shape from present to target at every change.
// R14: Linear ramp time is the time from 0 Hz to the ramp reference frequency.
// R15: The output frequency is updated once per fixed control tick by the shaped increment.
module sfr_start_ramp #(
  parameter TICK_CYCLES = `SFR_TICK_NS / `SFR_CLK_NS,
  parameter FW          = `SFR_FW,
  parameter TW          = `SFR_TW,
  parameter AW          = `SFR_AW
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          startPin,
  input  wire          reversePin,
  input  wire [FW-1:0] frequencyCommand,
  input  wire [FW-1:0] startingFrequencySetting,
  input  wire [15:0]   startHoldDuration,
  input  wire [1:0]    rampPatternSelect,
  input  wire [FW-1:0] minimumFrequencySetting,
  input  wire [FW-1:0] baseFrequencySetting,
  input  wire [FW-1:0] rampReferenceFrequency,
  input  wire [TW-1:0] accelTimeSetting,
  input  wire [TW-1:0] decelTimeSetting,
  output reg  [FW-1:0] outFreq_reg,
  output reg           reverse_reg,
  output reg           running_reg,
  output reg           holding_reg
);

  wire          startLvl;
  wire          reverseLvl;
  reg  [1:0]    state_reg;
  reg  [31:0]   tickCnt_reg;
  reg           tick_reg;
  reg  [15:0]   holdCnt_reg;
  reg  [AW-1:0] acc_reg;
  reg  [FW-1:0] origin_reg;
  reg  [FW-1:0] lastTarget_reg;
  reg           revPending_reg;

  reg  [FW-1:0] startVal;
  reg  [15:0]   holdVal;
  reg  [1:0]    pattern;
  reg  [FW-1:0] effCmd;
  reg  [FW-1:0] runTarget;
  reg  [FW-1:0] rampRef;
  reg  [TW-1:0] rampTime;
  reg  [AW-1:0] inc;
  reg  [FW-1:0] span;
  reg  [FW-1:0] doneDist;
  reg  [FW-1:0] remainDist;
  reg  [AW-1:0] refFull;
  reg  [AW-1:0] refHalf;
  reg  [AW-1:0] refBig;

  wire          holdEnabled;
  wire          cmdOk;
  wire          accelerating;
  wire          divStart;
  wire [AW-1:0] quotient;
  wire [TW-1:0] remainder;
  wire          divBusy;
  wire          divDone;
  wire [AW-1:0] upSum;
  wire [FW-1:0] holdFreq;

  sfr_pin_sync #(
    .WIDTH (2)
  ) uPinSync (
    .clk        (clk),
    .rst        (rst),
    .pinIn      ({reversePin, startPin}),
    .pinOut_reg ({reverseLvl, startLvl})
  );

  // Settings outside their range fall back to the defaults
  always @*
  begin
    // R01 start setting
    startVal = startingFrequencySetting;
    if (startingFrequencySetting > `SFR_START_MAX)
      startVal = `SFR_START_DEF;
    // R02 hold range
    holdVal = startHoldDuration;
    if (startHoldDuration > `SFR_HOLD_MAX)
      holdVal = `SFR_HOLD_OFF;
    // R09 pattern decode
    pattern = rampPatternSelect;
    if (rampPatternSelect > `SFR_PAT_SB)
      pattern = `SFR_PAT_LIN;
    // R08 preset minimum
    effCmd = frequencyCommand;
    if ((startVal <= minimumFrequencySetting) &&
        (frequencyCommand < minimumFrequencySetting))
      effCmd = minimumFrequencySetting;
  end

  assign holdEnabled = (holdVal != `SFR_HOLD_OFF);
  // R03 command threshold
  assign cmdOk = (effCmd >= startVal);
  // R05 zero start hold
  assign holdFreq = (startVal == {FW{1'b0}}) ? `SFR_HOLD_FREQ_ZERO
                                             : startVal;

  // A pending reversal forces the target to zero first
  always @*
  begin
    runTarget = {FW{1'b0}};
    if (startLvl && cmdOk && !revPending_reg &&
        (reverseLvl == reverse_reg))
      runTarget = effCmd;
  end

  assign accelerating = (runTarget > outFreq_reg);

  // Ramp reference and time per pattern and direction
  always @*
  begin
    // R14 linear reference
    rampRef = rampReferenceFrequency;
    // R12 base reference
    if (pattern == `SFR_PAT_SA)
      rampRef = baseFrequencySetting;
    rampTime = accelerating ? accelTimeSetting : decelTimeSetting;
    refFull = {{(AW-FW){1'b0}}, rampRef};
    refHalf = {{(AW-FW+1){1'b0}}, rampRef[FW-1:1]};
    refBig  = refFull + refHalf;
    span = (lastTarget_reg > origin_reg) ? lastTarget_reg - origin_reg
                                         : origin_reg - lastTarget_reg;
    doneDist = (outFreq_reg > origin_reg) ? outFreq_reg - origin_reg
                                          : origin_reg - outFreq_reg;
    remainDist = (runTarget > outFreq_reg) ? runTarget - outFreq_reg
                                           : outFreq_reg - runTarget;
    case (pattern)
      `SFR_PAT_SA:
      begin
        // R11 base inflection
        if (outFreq_reg >= baseFrequencySetting)
          inc = refHalf;
        else if (outFreq_reg < {1'b0, baseFrequencySetting[FW-1:1]})
          inc = refHalf;
        else
          inc = refBig;
      end
      `SFR_PAT_SB:
      begin
        // R13 present to target
        if (({doneDist, 2'b00} < {2'b00, span}) ||
            ({remainDist, 2'b00} < {2'b00, span}))
          inc = refHalf;
        else
          inc = refBig;
      end
      default:
        // R10 constant slope
        inc = refFull;
    endcase
  end

  // Fractional error carries over between ticks so slopes stay exact
  assign divStart = tick_reg && (state_reg == `SFR_ST_RUN) &&
                    (outFreq_reg != runTarget) &&
                    (rampTime != {TW{1'b0}}) && !divBusy;

  sfr_step_div #(
    .NW (AW),
    .DW (TW)
  ) uStepDiv (
    .clk           (clk),
    .rst           (rst),
    .start         (divStart),
    .dividend      (acc_reg + inc),
    .divisor       (rampTime),
    .quotient_reg  (quotient),
    .remainder_reg (remainder),
    .busy_reg      (divBusy),
    .done_reg      (divDone)
  );

  assign upSum = {{(AW-FW){1'b0}}, outFreq_reg} + quotient;

  // R15 control tick
  always @(posedge clk)
  begin
    if (rst)
    begin
      tickCnt_reg <= 32'h00000000;
      tick_reg    <= 1'b0;
    end
    else if (tickCnt_reg >= TICK_CYCLES - 1)
    begin
      tickCnt_reg <= 32'h00000000;
      tick_reg    <= 1'b1;
    end
    else
    begin
      tickCnt_reg <= tickCnt_reg + 32'h00000001;
      tick_reg    <= 1'b0;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg      <= `SFR_ST_IDLE;
      holdCnt_reg    <= 16'h0000;
      acc_reg        <= {AW{1'b0}};
      origin_reg     <= {FW{1'b0}};
      lastTarget_reg <= {FW{1'b0}};
      revPending_reg <= 1'b0;
      outFreq_reg    <= {FW{1'b0}};
      reverse_reg    <= 1'b0;
      running_reg    <= 1'b0;
      holding_reg    <= 1'b0;
    end
    else
    begin
      // S-curve B starts a fresh segment at every target change
      if (runTarget != lastTarget_reg)
      begin
        origin_reg     <= outFreq_reg;
        lastTarget_reg <= runTarget;
        acc_reg        <= {AW{1'b0}};
      end
      case (state_reg)
        `SFR_ST_IDLE:
        begin
          outFreq_reg <= {FW{1'b0}};
          reverse_reg <= reverseLvl;
          if (!startLvl)
            revPending_reg <= 1'b0;
          // R03 start gate
          else if (cmdOk)
          begin
            revPending_reg <= 1'b0;
            running_reg    <= 1'b1;
            // R07 reversal skips hold
            if (holdEnabled && !revPending_reg)
            begin
              // R04 enter hold
              state_reg   <= `SFR_ST_HOLD;
              holdCnt_reg <= 16'h0000;
              holding_reg <= 1'b1;
              outFreq_reg <= holdFreq;
            end
            else
            begin
              // R01 first frequency
              state_reg   <= `SFR_ST_RUN;
              outFreq_reg <= startVal;
            end
          end
        end
        `SFR_ST_HOLD:
        begin
          // R06 abort hold
          if (!startLvl)
          begin
            state_reg   <= `SFR_ST_RUN;
            holding_reg <= 1'b0;
          end
          else if (reverseLvl != reverse_reg)
          begin
            revPending_reg <= 1'b1;
            state_reg      <= `SFR_ST_RUN;
            holding_reg    <= 1'b0;
          end
          // R04 hold timing
          else if (tick_reg)
          begin
            holdCnt_reg <= holdCnt_reg + 16'h0001;
            if (holdCnt_reg + 16'h0001 >= holdVal)
            begin
              state_reg   <= `SFR_ST_RUN;
              holding_reg <= 1'b0;
            end
          end
        end
        `SFR_ST_RUN:
        begin
          if (startLvl && (reverseLvl != reverse_reg))
            revPending_reg <= 1'b1;
          if ((runTarget == {FW{1'b0}}) && (outFreq_reg == {FW{1'b0}}))
          begin
            // R07 restart after reversal
            state_reg   <= `SFR_ST_IDLE;
            running_reg <= 1'b0;
          end
          else if (tick_reg && (rampTime == {TW{1'b0}}) && !divBusy)
            outFreq_reg <= runTarget;
          else if (divDone)
          begin
            // R15 apply step
            acc_reg <= {{(AW-TW){1'b0}}, remainder};
            if (accelerating)
              outFreq_reg <= (upSum > {{(AW-FW){1'b0}}, runTarget}) ?
                             runTarget : upSum[FW-1:0];
            else if (quotient >= {{(AW-FW){1'b0}},
                                  outFreq_reg - runTarget})
              outFreq_reg <= runTarget;
            else
              outFreq_reg <= outFreq_reg - quotient[FW-1:0];
          end
        end
        default:
        begin
          state_reg   <= `SFR_ST_IDLE;
          running_reg <= 1'b0;
          holding_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule // sfr_start_ramp

`default_nettype wire

// *** rtl/sfr_step_div.v ***
`timescale 1ns/10ps
`default_nettype none

module sfr_step_div #(
  parameter NW = 24,
  parameter DW = 20
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          start,
  input  wire [NW-1:0] dividend,
  input  wire [DW-1:0] divisor,
  output reg  [NW-1:0] quotient_reg,
  output reg  [DW-1:0] remainder_reg,
  output reg           busy_reg,
  output reg           done_reg
);

  reg  [DW-1:0] dvs_reg;
  reg  [7:0]    count_reg;
  wire [DW:0]   trial;
  wire [DW:0]   shifted;

  assign shifted = {remainder_reg, quotient_reg[NW-1]};
  assign trial   = shifted - {1'b0, dvs_reg};

  // Restoring division, one quotient bit per clock
  always @(posedge clk)
  begin
    if (rst)
    begin
      quotient_reg  <= {NW{1'b0}};
      remainder_reg <= {DW{1'b0}};
      dvs_reg       <= {DW{1'b0}};
      count_reg     <= 8'h00;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!busy_reg && start)
      begin
        quotient_reg  <= dividend;
        remainder_reg <= {DW{1'b0}};
        dvs_reg       <= divisor;
        count_reg     <= NW[7:0];
        busy_reg      <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (!trial[DW])
        begin
          remainder_reg <= trial[DW-1:0];
          quotient_reg  <= {quotient_reg[NW-2:0], 1'b1};
        end
        else
        begin
          remainder_reg <= shifted[DW-1:0];
          quotient_reg  <= {quotient_reg[NW-2:0], 1'b0};
        end
        count_reg <= count_reg - 8'h01;
        if (count_reg == 8'h01)
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

endmodule // sfr_step_div

`default_nettype wire
